// ---- src/gecpg_pkg.sv ----
// Constants and field layout of the gated event counter.
// What this block does
// R1: Pulse mode counts down delay phase then pulse phase, repeating, to pin.
// R2: Ratio zero forces a pulse phase of three timebase cycles.
// R3: Ratio one forces a delay phase of three timebase cycles.
// R4: Active high: delay low, pulse high; active low inverts both.
// R5: Gate ignored mode runs as soon as host start arrives.
// R6: Level gating advances only while gate is high, or only while low.
// R7: Edge gating waits after start for first rising or falling gate edge.
// R8: Count input is the source pin or a selected internal timebase.
// R9: Timebases 1M,100k,10k,1k,100 Hz (16-bit); 20M,100k Hz (24-bit).
// R10: Widths: 24-bit single, or 16-bit single and 32-bit cascaded.
// R11: Cascade chains into fixed ring neighbour via carry in and out.
// R12: Halt at terminal stops and sets overflow; absent in 24-bit width.
// R13: Continuous rolls over; 24-bit sets overflow, 16-bit leaves it.
// R14: Count on rising or falling edge of source or timebase, selectable.
// R15: Overflow reads one after a halt or a 24-bit rollover at terminal count, else zero.
// R16: Host stop halts counting at once, mid phase or mid count.
// R17: Reload values take effect only at start or at a phase boundary.
// R18: Count is readable any time without disturbing the counter.
`default_nettype none
package gecpg_pkg;
  // Clock and timebases
  localparam int CLK_HZ = 250_000_000;
  localparam int TB_1M_HZ = 1_000_000;
  localparam int TB_100K_HZ = 100_000;
  localparam int TB_10K_HZ = 10_000;
  localparam int TB_1K_HZ = 1_000;
  localparam int TB_100_HZ = 100;
  localparam int TB_20M_HZ = 20_000_000;
  localparam int DIV_1M = CLK_HZ / TB_1M_HZ;
  localparam int DIV_100K = CLK_HZ / TB_100K_HZ;
  localparam int DIV_10K = CLK_HZ / TB_10K_HZ;
  localparam int DIV_1K = CLK_HZ / TB_1K_HZ;
  localparam int DIV_100 = CLK_HZ / TB_100_HZ;
  localparam int DIV_20M = CLK_HZ / TB_20M_HZ;
  localparam logic [31:0] MIN_PHASE = 32'h0000_0003;
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CFG = 5'h04;
  localparam logic [4:0] OFS_DELAY = 5'h08;
  localparam logic [4:0] OFS_PULSE = 5'h0C;
  localparam logic [4:0] OFS_COUNT = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_CLEAR = 5'h18;
  localparam logic [4:0] OFS_ENABLE = 5'h1C;
  // Control bits
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  // Configuration fields
  localparam int CFG_PULSE_MODE = 0;
  localparam int CFG_GATE_LSB = 1;
  localparam int CFG_SENSE = 4;
  localparam int CFG_CLKSEL_LSB = 5;
  localparam int CFG_HALT = 8;
  localparam int CFG_FALL_EDGE = 9;
  localparam int CFG_WIDTH_LSB = 10;
  localparam int CFG_CHAIN = 12;
  localparam int CFG_RATIO0 = 13;
  localparam int CFG_RATIO1 = 14;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // Status and interrupt bits
  localparam int ST_OVERFLOW = 0;
  localparam int ST_HALTED = 1;
  localparam int ST_CYCLE = 2;
  localparam int NUM_EVT = 3;
  // Field encodings
  localparam logic [2:0] GATE_IGNORED = 3'h0;
  localparam logic [2:0] GATE_HIGH = 3'h1;
  localparam logic [2:0] GATE_LOW = 3'h2;
  localparam logic [2:0] GATE_RISE = 3'h3;
  localparam logic [2:0] GATE_FALL = 3'h4;
  localparam logic [2:0] CLK_SOURCE_PIN = 3'h0;
  localparam logic [1:0] WIDTH_16 = 2'h0;
  localparam logic [1:0] WIDTH_32 = 2'h1;
  localparam logic [1:0] WIDTH_24 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {GECPG_IDLE, GECPG_WAIT, GECPG_RUN} gecpg_state_t;
endpackage
`default_nettype wire

// ---- src/gecpg_top.sv ----
// Counter channel with pulse train output, gating, cascade and AXI4-Lite.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module gecpg_top #(
  parameter int DIV_10K = gecpg_pkg::DIV_10K,
  parameter int DIV_1K = gecpg_pkg::DIV_1K,
  parameter int DIV_100 = gecpg_pkg::DIV_100,
  parameter int DIV_100K = gecpg_pkg::DIV_100K
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External pins
  input wire logic source_pin,
  input wire logic gate_pin,
  output logic pulse_out,
  // Cascade ring to the fixed neighbours
  input wire logic carry_in,
  output logic carry_out,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Terminal count for the selected width
  function automatic logic [31:0] term_of(input logic [1:0] w);
    unique case (w)
      gecpg_pkg::WIDTH_32: term_of = 32'hFFFF_FFFF;
      gecpg_pkg::WIDTH_24: term_of = 32'h00FF_FFFF;
      default: term_of = 32'h0000_FFFF;
    endcase
  endfunction

  // Phase reload: forced minimum, else at least one tick
  function automatic logic [31:0] plen_m1(input logic [31:0] rl,
                                          input logic force_min);
    logic [31:0] n;
    n = force_min ? gecpg_pkg::MIN_PHASE : rl;
    if (n == 32'h0) begin
      n = 32'h1;
    end
    return n - 32'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [31:0] cfg_q;
  logic [31:0] delay_q;
  logic [31:0] pulse_q;
  logic [31:0] count_q;
  logic [gecpg_pkg::NUM_EVT-1:0] status_q;
  logic [gecpg_pkg::NUM_EVT-1:0] irq_en_q;
  logic start_q;
  logic stop_q;
  logic phase_q;
  gecpg_pkg::gecpg_state_t state_q;

  wire logic pulse_mode = cfg_q[gecpg_pkg::CFG_PULSE_MODE];
  wire logic [2:0] gate_sel = cfg_q[gecpg_pkg::CFG_GATE_LSB +: 3];
  wire logic sense = cfg_q[gecpg_pkg::CFG_SENSE];
  wire logic [2:0] clk_sel = cfg_q[gecpg_pkg::CFG_CLKSEL_LSB +: 3];
  wire logic [1:0] width_sel = cfg_q[gecpg_pkg::CFG_WIDTH_LSB +: 2];
  wire logic is24 = (width_sel == gecpg_pkg::WIDTH_24);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  logic aw_have_q;
  logic w_have_q;
  logic [4:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire logic do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire logic wr_hit = do_write && (waddr_q[1:0] == 2'h0);
  logic [gecpg_pkg::NUM_EVT-1:0] clr_w;

  // Address and data in either order; each held until used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 5'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gecpg_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_hit && waddr_q != gecpg_pkg::OFS_COUNT &&
                        waddr_q != gecpg_pkg::OFS_STATUS) ?
                       gecpg_pkg::RESP_OKAY : gecpg_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable registers; reloads are used at start or a boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= gecpg_pkg::CFG_RESET;
      delay_q <= 32'h0;
      pulse_q <= 32'h0;
      irq_en_q <= '0;
    end else if (wr_hit) begin
      unique case (waddr_q)
        gecpg_pkg::OFS_CFG: cfg_q <= wmerge(cfg_q, wdata_q, wstrb_q);
        gecpg_pkg::OFS_DELAY: delay_q <= wmerge(delay_q, wdata_q, wstrb_q); // R17
        gecpg_pkg::OFS_PULSE: pulse_q <= wmerge(pulse_q, wdata_q, wstrb_q); // R17
        gecpg_pkg::OFS_ENABLE: irq_en_q <= wdata_q[gecpg_pkg::NUM_EVT-1:0];
        default: ;
      endcase
    end
  end

  // Start and stop are one-cycle command pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      start_q <= wr_hit && waddr_q == gecpg_pkg::OFS_CTRL &&
                 wstrb_q[0] && wdata_q[gecpg_pkg::CTRL_START];
      stop_q <= wr_hit && waddr_q == gecpg_pkg::OFS_CTRL &&
                wstrb_q[0] && wdata_q[gecpg_pkg::CTRL_STOP];
    end
  end

  assign clr_w = (wr_hit && waddr_q == gecpg_pkg::OFS_CLEAR) ?
                 wdata_q[gecpg_pkg::NUM_EVT-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  // Count is sampled, never cleared, by a read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= gecpg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= gecpg_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        gecpg_pkg::OFS_CTRL: s_axi_rdata <= {28'h0, pulse_out,
          phase_q, state_q == gecpg_pkg::GECPG_WAIT,
          state_q == gecpg_pkg::GECPG_RUN};
        gecpg_pkg::OFS_CFG: s_axi_rdata <= cfg_q;
        gecpg_pkg::OFS_DELAY: s_axi_rdata <= delay_q;
        gecpg_pkg::OFS_PULSE: s_axi_rdata <= pulse_q;
        gecpg_pkg::OFS_COUNT: s_axi_rdata <= count_q; // R18
        gecpg_pkg::OFS_STATUS: s_axi_rdata <= {29'h0, status_q}; // R15
        gecpg_pkg::OFS_ENABLE: s_axi_rdata <= {29'h0, irq_en_q};
        gecpg_pkg::OFS_CLEAR: s_axi_rdata <= 32'h0;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= gecpg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect

  logic [2:0] src_sync_q;
  logic [2:0] gate_sync_q;
  logic src_f_q;
  logic src_prev_q;
  logic gate_f_q;
  logic gate_prev_q;

  // A level counts only once the second and third stage agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sync_q <= 3'h0;
      gate_sync_q <= 3'h0;
      src_f_q <= 1'b0;
      src_prev_q <= 1'b0;
      gate_f_q <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      src_sync_q <= {src_sync_q[1:0], source_pin};
      gate_sync_q <= {gate_sync_q[1:0], gate_pin};
      if (src_sync_q[1] == src_sync_q[2]) begin
        src_f_q <= src_sync_q[2];
      end
      if (gate_sync_q[1] == gate_sync_q[2]) begin
        gate_f_q <= gate_sync_q[2];
      end
      src_prev_q <= src_f_q;
      gate_prev_q <= gate_f_q;
    end
  end

  wire logic src_rise = src_f_q && !src_prev_q;
  wire logic src_fall = !src_f_q && src_prev_q;
  wire logic gate_rise = gate_f_q && !gate_prev_q;
  wire logic gate_fall = !gate_f_q && gate_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Internal timebase divider

  logic [31:0] div_cnt_q;
  logic [31:0] div_n;
  logic tb_ok;

  // Ratio per select; the other width family's timebases are dead
  always_comb begin
    div_n = 32'(gecpg_pkg::DIV_1M);
    tb_ok = !is24;
    unique case (clk_sel)
      3'h1: div_n = 32'(gecpg_pkg::DIV_1M); // R9
      3'h2: div_n = 32'(DIV_100K);
      3'h3: div_n = 32'(DIV_10K);
      3'h4: div_n = 32'(DIV_1K);
      3'h5: div_n = 32'(DIV_100);
      3'h6: begin
        div_n = 32'(gecpg_pkg::DIV_20M); // R9
        tb_ok = is24;
      end
      3'h7: begin
        div_n = 32'(DIV_100K);
        tb_ok = is24;
      end
      default: tb_ok = 1'b0;
    endcase
  end

  // Free running so the timebase phase is independent of start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 32'h0;
    end else if (div_cnt_q >= div_n - 32'h1) begin
      div_cnt_q <= 32'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 32'h1;
    end
  end

  wire logic tb_rise = (div_cnt_q == 32'h0);
  wire logic tb_fall = (div_cnt_q == {1'b0, div_n[31:1]});

  ////////////////////////////////////////////////////////////////////////////
  // Count tick selection and gating

  logic tick;
  logic gate_en;

  // Source, timebase or neighbour carry; rising or falling edge
  always_comb begin
    if (cfg_q[gecpg_pkg::CFG_CHAIN] && width_sel == gecpg_pkg::WIDTH_32) begin
      tick = carry_in; // R11
    end else if (clk_sel == gecpg_pkg::CLK_SOURCE_PIN) begin
      tick = cfg_q[gecpg_pkg::CFG_FALL_EDGE] ? src_fall : src_rise; // R8 R14
    end else begin
      tick = tb_ok && (cfg_q[gecpg_pkg::CFG_FALL_EDGE] ? tb_fall : tb_rise); // R8 R14
    end
  end

  // Level gating qualifies every tick while running
  always_comb begin
    unique case (gate_sel)
      gecpg_pkg::GATE_HIGH: gate_en = gate_f_q; // R6
      gecpg_pkg::GATE_LOW: gate_en = !gate_f_q; // R6
      default: gate_en = 1'b1; // R5
    endcase
  end

  wire logic running = (state_q == gecpg_pkg::GECPG_RUN);
  wire logic step = running && gate_en && tick;
  wire logic [31:0] term = term_of(width_sel); // R10
  wire logic at_term = (count_q == term);
  wire logic halt_mode = cfg_q[gecpg_pkg::CFG_HALT] && !is24; // R12
  wire logic halt_hit = step && !pulse_mode && at_term && halt_mode;
  wire logic roll_hit = step && !pulse_mode && at_term && !halt_mode;
  wire logic phase_end = step && pulse_mode && count_q == 32'h0;
  wire logic edge_go = (gate_sel == gecpg_pkg::GATE_RISE && gate_rise) ||
                       (gate_sel == gecpg_pkg::GATE_FALL && gate_fall);

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  // Stop wins over everything, even a same-cycle start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= gecpg_pkg::GECPG_IDLE;
    end else if (stop_q) begin
      state_q <= gecpg_pkg::GECPG_IDLE; // R16
    end else if (start_q) begin
      state_q <= (gate_sel == gecpg_pkg::GATE_RISE ||
                  gate_sel == gecpg_pkg::GATE_FALL) ?
                 gecpg_pkg::GECPG_WAIT : gecpg_pkg::GECPG_RUN; // R5 R7
    end else begin
      unique case (state_q)
        gecpg_pkg::GECPG_WAIT: begin
          if (edge_go) begin
            state_q <= gecpg_pkg::GECPG_RUN; // R7
          end
        end
        gecpg_pkg::GECPG_RUN: begin
          if (halt_hit) begin
            state_q <= gecpg_pkg::GECPG_IDLE; // R12
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter datapath

  // Up count for events, down count per phase for pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 32'h0;
      phase_q <= 1'b0;
    end else if (start_q && !stop_q) begin
      phase_q <= 1'b0;
      count_q <= pulse_mode ?
        plen_m1(delay_q, cfg_q[gecpg_pkg::CFG_RATIO1]) : 32'h0; // R3 R17
    end else if (phase_end) begin
      phase_q <= !phase_q; // R1
      count_q <= phase_q ?
        plen_m1(delay_q, cfg_q[gecpg_pkg::CFG_RATIO1]) : // R3 R17
        plen_m1(pulse_q, cfg_q[gecpg_pkg::CFG_RATIO0]); // R2 R17
    end else if (step && pulse_mode) begin
      count_q <= count_q - 32'h1; // R1
    end else if (roll_hit) begin
      count_q <= 32'h0; // R13
    end else if (step && !halt_hit) begin
      count_q <= count_q + 32'h1;
    end
  end

  // Idle rests at the delay level of the chosen sense
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out <= 1'b0;
      carry_out <= 1'b0;
    end else begin
      pulse_out <= (pulse_mode && running && phase_q) ^ sense; // R4
      carry_out <= roll_hit || halt_hit; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt

  logic [gecpg_pkg::NUM_EVT-1:0] evt;

  always_comb begin
    evt = '0;
    evt[gecpg_pkg::ST_OVERFLOW] = halt_hit || (roll_hit && is24); // R12 R13
    evt[gecpg_pkg::ST_HALTED] = halt_hit;
    evt[gecpg_pkg::ST_CYCLE] = phase_end && phase_q;
  end

  // A new event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr_w) | evt; // R15
      irq <= |(status_q & irq_en_q);
    end
  end

endmodule
`default_nettype wire

// ---- testbench/gecpg_pins.sv ----
// Behavioural model of the external source and gate signals.
`default_nettype none
module gecpg_pins (
  // Clock that paces the edges
  input wire logic aclk,
  // Pins seen by the counter
  output logic source_pin,
  output logic gate_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both lines idle low, like a pulled-down input
  initial begin
    source_pin = 1'b0;
    gate_pin = 1'b0;
  end
  // Eight clocks per level outlast the synchroniser
  task automatic send(input int n);
    repeat (n) begin
      @(posedge aclk);
      source_pin <= 1'b1;
      repeat (8) @(posedge aclk);
      source_pin <= 1'b0;
      repeat (7) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
  endtask
  // Gate change, then time to pass the synchroniser
  task automatic set_gate(input logic v);
    @(posedge aclk);
    gate_pin <= v;
    repeat (8) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/gecpg_top_props.sv ----
// Port checker for the counter channel, bound to its top module.
`default_nettype none
module gecpg_top_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Outputs of the counter
  input wire logic carry_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  // A write taken whole is answered two edges on
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data late");
  // A response stands until it is accepted
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  // Accepted response frees the write channels
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##0 s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write channel not freed");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("second write taken early");
  // Carry is one cycle, so it counts once
  property p_carry_pulse;
    carry_out |=> !carry_out;
  endproperty
  a_carry_pulse: assert property (p_carry_pulse)
    else $error("carry pulse too long");
  property p_irq_reset;
    $rose(aresetn) |-> !irq ##1 !irq;
  endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("interrupt high after reset");
endmodule
bind gecpg_top gecpg_top_props gecpg_top_props_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .carry_out, .irq);
`default_nettype wire

// ---- testbench/gecpg_top_tb.sv ----
// Self-checking bench for the counter channel over its register bus.
`default_nettype none
module gecpg_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, source_pin, gate_pin;
  logic pulse_out, carry_in, carry_out, irq;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count, num_checks, nh, nl;
  logic [2:0] gm[4];
  logic [31:0] xs[4];
  int eh[4], el[4];
  // Short 100 kHz divider: ticks ten clocks apart
  gecpg_top #(.DIV_100K(10))
    gecpg_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_pin, .gate_pin,
    .pulse_out, .carry_in, .carry_out, .irq);
  gecpg_pins gecpg_pins_i (.aclk, .source_pin, .gate_pin);
  // Clock at 250 MHz
  always #2 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] bit_of(input int i);
    bit_of = 32'h1 << i;
  endfunction
  function automatic logic [31:0] cf(input logic [2:0] g, s,
                                     input logic [31:0] x);
    cf = x | (32'(g) << gecpg_pkg::CFG_GATE_LSB)
         | (32'(s) << gecpg_pkg::CFG_CLKSEL_LSB);
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er = gecpg_pkg::RESP_OKAY);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (!s_axi_bvalid && t < 100);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a,
                     input logic [31:0] e);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (!s_axi_rvalid && t < 100);
    s_axi_rready <= 1'b0;
    chk(nm, s_axi_rdata, e);
    @(posedge aclk);
  endtask
  task automatic ctl(input bit s);
    wr(gecpg_pkg::OFS_CTRL,
       bit_of(s ? gecpg_pkg::CTRL_STOP : gecpg_pkg::CTRL_START));
  endtask
  // Cycles at one level, once it is first seen
  task automatic meas(input logic lv, output int n);
    n = 0;
    while (pulse_out !== lv) @(posedge aclk);
    while (pulse_out === lv) begin
      n++;
      @(posedge aclk);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    stop_test();
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, carry_in, err_count, num_checks} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    gm = '{gecpg_pkg::GATE_HIGH, gecpg_pkg::GATE_LOW,
           gecpg_pkg::GATE_RISE, gecpg_pkg::GATE_FALL};
    xs = '{32'h0, bit_of(gecpg_pkg::CFG_SENSE),
           bit_of(gecpg_pkg::CFG_RATIO0), bit_of(gecpg_pkg::CFG_RATIO1)};
    eh = '{50, 40, 30, 50};
    el = '{40, 50, 40, 30};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc("cfg", gecpg_pkg::OFS_CFG, gecpg_pkg::CFG_RESET);
    rdc("status", gecpg_pkg::OFS_STATUS, 32'h0);
    wr(gecpg_pkg::OFS_COUNT, 32'h5, gecpg_pkg::RESP_SLVERR);
    wr(5'h02, 32'h1, gecpg_pkg::RESP_SLVERR);
    // Only the enabled byte lane lands
    s_axi_wstrb <= 4'h2;
    wr(gecpg_pkg::OFS_DELAY, 32'hFFFF_FFFF);
    rdc("lanes", gecpg_pkg::OFS_DELAY, 32'h0000_FF00);
    s_axi_wstrb <= 4'hF;
    // Source pin on either edge, read mid-run, then stopped
    for (int e = 0; e < 2; e++) begin
      wr(gecpg_pkg::OFS_CFG, cf(gecpg_pkg::GATE_IGNORED,
         gecpg_pkg::CLK_SOURCE_PIN, e ? bit_of(gecpg_pkg::CFG_FALL_EDGE)
         : 32'h0));
      ctl(0);
      gecpg_pins_i.send(3);
      rdc("count", gecpg_pkg::OFS_COUNT, 32'h3);
      gecpg_pins_i.send(2);
      rdc("count", gecpg_pkg::OFS_COUNT, 32'h5);
      ctl(1);
      gecpg_pins_i.send(2);
      rdc("count", gecpg_pkg::OFS_COUNT, 32'h5);
    end
    // Gate modes: blocked, then released
    for (int g = 0; g < 4; g++) begin
      wr(gecpg_pkg::OFS_CFG, cf(gm[g], gecpg_pkg::CLK_SOURCE_PIN, 32'h0));
      gecpg_pins_i.set_gate(g[0]);
      ctl(0);
      gecpg_pins_i.send(3);
      rdc("gated", gecpg_pkg::OFS_COUNT, 32'h0);
      gecpg_pins_i.set_gate(!g[0]);
      gecpg_pins_i.send(4);
      rdc("open", gecpg_pkg::OFS_COUNT, 32'h4);
      ctl(1);
    end
    // Cascaded width counts the neighbour's carry pulses
    wr(gecpg_pkg::OFS_CFG, bit_of(gecpg_pkg::CFG_CHAIN) |
       (32'(gecpg_pkg::WIDTH_32) << gecpg_pkg::CFG_WIDTH_LSB));
    ctl(0);
    repeat (3) begin
      @(posedge aclk);
      carry_in <= 1'b1;
      @(posedge aclk);
      carry_in <= 1'b0;
    end
    rdc("chain", gecpg_pkg::OFS_COUNT, 32'h3);
    ctl(1);
    // Pulse train on the 100 kHz base: delay 4, pulse 5 ticks
    wr(gecpg_pkg::OFS_DELAY, 32'h4);
    wr(gecpg_pkg::OFS_PULSE, 32'h5);
    for (int i = 0; i < 4; i++) begin
      wr(gecpg_pkg::OFS_CFG, cf(gecpg_pkg::GATE_IGNORED, 3'h2,
         xs[i] | bit_of(gecpg_pkg::CFG_PULSE_MODE)));
      ctl(0);
      meas(1'b1, nh);
      meas(1'b0, nl);
      meas(1'b1, nh);
      chk("high", nh, eh[i]);
      chk("low", nl, el[i]);
      if (i < 3) ctl(1);
    end
    // Cycle event raises irq only while enabled
    chk("irq off", 32'(irq), 32'h0);
    wr(gecpg_pkg::OFS_ENABLE, bit_of(gecpg_pkg::ST_CYCLE));
    repeat (2) @(posedge aclk);
    chk("irq on", 32'(irq), 32'h1);
    wr(gecpg_pkg::OFS_ENABLE, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq mask", 32'(irq), 32'h0);
    wr(gecpg_pkg::OFS_ENABLE, bit_of(gecpg_pkg::ST_CYCLE));
    ctl(1);
    repeat (4) @(posedge aclk);
    chk("idle out", 32'(pulse_out), 32'h0);
    wr(gecpg_pkg::OFS_CLEAR, bit_of(gecpg_pkg::ST_CYCLE));
    rdc("status", gecpg_pkg::OFS_STATUS, 32'h0);
    chk("irq clr", 32'(irq), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
